// ==== rtl/sac_cell_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// sample cell store, registered read
// ----------------------------------------
module sac_cell_mem #(
   parameter int DW = 12,
   parameter int AW = 6
) (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1]; // cell array
   logic [DW-1:0] rd_data_ff; // read register

   // no reset on the array: contents are undefined until written
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data_ff <= mem[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;
endmodule

`default_nettype wire

// ==== rtl/sac_pkg.sv ====
`default_nettype none

package sac_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int CH_N = 32;       // converter channels
   localparam int CH_AW = 5;       // channel select width
   localparam int CELL_N = 64;     // sample cells
   localparam int CELL_AW = 6;     // cell address width
   localparam int RES_W = 12;      // result word width
   localparam int CFG_W = 32;      // config string length (plain default)
   localparam int AXI_AW = 8;      // bus address width

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_LEVEL = 8'h04;
   localparam logic [7:0] REG_CONFIG = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [11:0] LEVEL_RST = 12'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // status bit positions
   // ----------------------------------------
   localparam int ST_DONE = 0;
   localparam int ST_COUNT = 1;
   localparam int ST_RAMP = 2;
   localparam int ST_CELL = 8;

   // ----------------------------------------
   // resolution: full count is all ones shifted by (3 - select)
   // ----------------------------------------
   localparam logic [11:0] FULL_12 = 12'hFFF;
   localparam logic [1:0] WSEL_MAX = 2'h3;

   // ----------------------------------------
   // conversion sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      SAC_IDLE = 3'b001,
      SAC_COUNT = 3'b010,
      SAC_DONE = 3'b100
   } sac_state_t;

   // ----------------------------------------
   // control pins arriving from the controller
   // ----------------------------------------
   typedef struct packed {
      logic width_select_hi;
      logic width_select_lo;
      logic conv_enable;
      logic converter_clock;
      logic result_output_enable;
      logic result_load;
      logic debounce_clear;
      logic comparator_clear;
      logic auto_zero_ctl;
      logic comparator_source_select;
      logic cell_write_strobe;
      logic [5:0] write_cell;
      logic read_enable;
      logic [5:0] read_cell;
      logic memory_output_link;
      logic correlator_clear;
      logic readout_amp_clear;
      logic config_shift_clock;
      logic config_latch_strobe;
      logic config_serial_in;
      logic config_string_clear;
      logic config_readback_select;
      logic [4:0] channel_select;
   } sac_pins_t;

endpackage

`default_nettype wire

// ==== rtl/sac_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module sac_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sac_pkg::sac_pins_t pins,
   output logic full_scale_done,
   output logic [sac_pkg::RES_W-1:0] result_data,
   output logic [sac_pkg::RES_W-1:0] result_oe_n,
   output logic config_serial_out,
   input wire logic [sac_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sac_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import sac_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   sac_pins_t s1_ff; // first stage, read only by s2
   sac_pins_t s2_ff; // safe copy of the pins
   sac_pins_t s3_ff; // one cycle older, for edges

   // every pin is asynchronous to clk_sys
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pins;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ----------------------------------------
   // decoded pin events
   // ----------------------------------------
   logic cclk_edge; // any converter clock transition
   logic en_s; // conversion enable level
   logic ramp_sel; // comparator looks at ramp
   logic shift_rise; // config shift clock rising
   logic strobe_rise; // config latch strobe rising
   logic rb_rise; // readback select rising
   logic cfg_clr; // config string clear
   logic [1:0] wsel; // width select, hi first
   logic [11:0] full_cnt; // final count for width

   // both edges count, so 2^(n-1) periods give 2^n codes
   assign cclk_edge = s2_ff.converter_clock ^ s3_ff.converter_clock;
   assign en_s = s2_ff.conv_enable;
   assign ramp_sel = s2_ff.comparator_source_select;
   assign shift_rise = s2_ff.config_shift_clock & ~s3_ff.config_shift_clock;
   assign strobe_rise = s2_ff.config_latch_strobe & ~s3_ff.config_latch_strobe;
   assign rb_rise = s2_ff.config_readback_select & ~s3_ff.config_readback_select;
   assign cfg_clr = s2_ff.config_string_clear;
   assign wsel = {s2_ff.width_select_hi, s2_ff.width_select_lo};
   // 00 -> 1FF (9 bit) up to 11 -> FFF (12 bit)
   assign full_cnt = FULL_12 >> (WSEL_MAX - wsel);

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   sac_state_t state_ff; // sequencer state
   sac_state_t nxt_state; // next state
   logic [11:0] cnt_ff; // conversion counter
   logic [11:0] nxt_cnt; // next counter value
   logic [11:0] cnt_inc; // counter plus one
   logic ramp_on_ff; // ramp generator running
   logic done_ff; // full-scale done output
   logic step; // counter advances this cycle

   assign cnt_inc = cnt_ff + 12'h001;
   assign step = (state_ff == SAC_COUNT) & cclk_edge;

   // controller keeps enable high past done until stop; an early drop aborts
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         SAC_IDLE: begin
            if (en_s) begin
               nxt_state = SAC_COUNT;
            end
         end
         SAC_COUNT: begin
            if (step) begin
               nxt_cnt = cnt_inc;
               if (cnt_inc >= full_cnt) begin
                  nxt_state = SAC_DONE;
               end
            end
         end
         SAC_DONE: begin
            nxt_state = SAC_DONE; // counter parked at full scale
         end
         default: begin
            nxt_state = SAC_IDLE;
         end
      endcase
      if (!en_s) begin
         nxt_state = SAC_IDLE;
         nxt_cnt = 12'h000;
      end
   end

   // ramp and counter leave reset in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SAC_IDLE;
         cnt_ff <= 12'h000;
         ramp_on_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ramp_on_ff <= (nxt_state == SAC_COUNT);
         done_ff <= (nxt_state == SAC_DONE);
      end
   end

   assign full_scale_done = done_ff;

   // ----------------------------------------
   // sample memory and readout amplifier
   // ----------------------------------------
   logic [11:0] level_ff; // software-set level stored on write
   logic [11:0] cell_rd; // cell read data
   logic rd_pend_ff; // cell data arrive next cycle
   logic [11:0] amp_ff; // readout amplifier output
   logic amp_clr; // amplifier or correlator reset

   sac_cell_mem #(
      .DW(RES_W),
      .AW(CELL_AW)
   ) u_mem (
      .clk_sys(clk_sys),
      .wr_en(s2_ff.cell_write_strobe),
      .wr_addr(s2_ff.write_cell),
      .wr_data(level_ff),
      .rd_en(s2_ff.read_enable),
      .rd_addr(s2_ff.read_cell),
      .rd_data(cell_rd)
   );

   assign amp_clr = s2_ff.readout_amp_clear | s2_ff.correlator_clear;

   // amplifier only follows the cell while the link is made
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_ff <= 1'b0;
         amp_ff <= 12'h000;
      end else begin
         rd_pend_ff <= s2_ff.read_enable;
         if (amp_clr) begin
            amp_ff <= 12'h000;
         end else if (rd_pend_ff && s2_ff.memory_output_link) begin
            amp_ff <= cell_rd;
         end
      end
   end

   // ----------------------------------------
   // per-channel comparators and latches
   // ----------------------------------------
   logic [11:0] conv_val [CH_N]; // converted counter data
   logic [11:0] out_latch [CH_N]; // loaded results
   logic cmp_clr; // comparator and zero reset
   logic db_clr; // debounce reset

   assign cmp_clr = s2_ff.comparator_clear | s2_ff.auto_zero_ctl;
   assign db_clr = s2_ff.debounce_clear;

   genvar gi;
   generate
      for (gi = 0; gi < CH_N; gi++) begin : g_ch
         logic tripped_ff; // debounced comparator decision
         logic [11:0] val_ff; // count captured at crossing
         logic [11:0] lat_ff; // output latch
         logic [11:0] lvl; // level seen by this channel
         // channels differ by index so each sees a distinct level while the link is made
         assign lvl = s2_ff.memory_output_link ? amp_ff + 12'(gi) : 12'h000;
         // once tripped the value freezes: a debounce against chatter
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               tripped_ff <= 1'b0;
               val_ff <= 12'h000;
               lat_ff <= 12'h000;
            end else begin
               if (cmp_clr) begin
                  tripped_ff <= 1'b0;
                  val_ff <= 12'h000;
               end else if (db_clr) begin
                  tripped_ff <= 1'b0;
               end else if (step && ramp_sel && !tripped_ff) begin
                  val_ff <= cnt_inc;
                  tripped_ff <= (cnt_inc >= lvl);
               end
               if (s2_ff.result_load) begin
                  lat_ff <= val_ff;
               end
            end
         end
         assign conv_val[gi] = val_ff;
         assign out_latch[gi] = lat_ff;
      end
   endgenerate

   // ----------------------------------------
   // result bus
   // ----------------------------------------
   logic [11:0] res_ff; // driven result word
   logic [11:0] oe_n_ff; // low while driving
   logic [11:0] sel_word; // selected channel latch

   assign sel_word = out_latch[s2_ff.channel_select];

   // bus floats unless output enable is high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         res_ff <= 12'h000;
         oe_n_ff <= 12'hFFF;
      end else begin
         res_ff <= s2_ff.result_output_enable ? sel_word : 12'h000;
         oe_n_ff <= {RES_W{~s2_ff.result_output_enable}};
      end
   end

   assign result_data = res_ff;
   assign result_oe_n = oe_n_ff;

   // ----------------------------------------
   // serial configuration string
   // ----------------------------------------
   logic [CFG_W-1:0] shift_ff; // shifted-in string
   logic [CFG_W-1:0] cfg_ff; // latched configuration
   logic [CFG_W-1:0] rb_ff; // readback copy
   logic sout_ff; // serial output

   // readback uses its own copy so the latched set stays put
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift_ff <= '0;
         cfg_ff <= '0;
         rb_ff <= '0;
         sout_ff <= 1'b0;
      end else if (cfg_clr) begin
         shift_ff <= '0;
         cfg_ff <= '0;
         rb_ff <= '0;
         sout_ff <= 1'b0;
      end else begin
         if (rb_rise) begin
            rb_ff <= cfg_ff;
         end else if (shift_rise && s2_ff.config_readback_select) begin
            rb_ff <= {rb_ff[CFG_W-2:0], 1'b0};
         end
         if (shift_rise && !s2_ff.config_readback_select) begin
            shift_ff <= {shift_ff[CFG_W-2:0], s2_ff.config_serial_in};
         end
         if (strobe_rise) begin
            cfg_ff <= shift_ff;
         end
         sout_ff <= s2_ff.config_readback_select ? rb_ff[CFG_W-1] : shift_ff[CFG_W-1];
      end
   end

   assign config_serial_out = sout_ff;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic aw_got_ff; // write address held
   logic w_got_ff; // write data held
   logic [7:0] waddr_ff; // held write address
   logic [31:0] wdata_ff; // held write data
   logic [3:0] wstrb_ff; // held strobes
   logic bvalid_ff; // write response pending
   logic [1:0] bresp_ff; // write response code
   logic rvalid_ff; // read response pending
   logic [31:0] rdata_ff; // read data
   logic [1:0] rresp_ff; // read response code
   logic aw_hs; // address taken
   logic w_hs; // data taken
   logic do_wr; // both halves present
   logic ar_hs; // read address taken
   logic [31:0] rd_mux; // read data select
   logic rd_ok; // mapped read address
   logic [31:0] status_w; // status word
   logic awready_ff; // write address ready
   logic wready_ff; // write data ready
   logic arready_ff; // read address ready
   logic nxt_aw_got; // address held after this edge
   logic nxt_w_got; // data held after this edge
   logic nxt_bvalid; // response pending after this edge
   logic nxt_rvalid; // read data pending after this edge

   assign aw_hs = s_axi_awvalid & ~aw_got_ff & ~bvalid_ff;
   assign w_hs = s_axi_wvalid & ~w_got_ff & ~bvalid_ff;
   assign do_wr = aw_got_ff & w_got_ff;
   assign ar_hs = s_axi_arvalid & ~rvalid_ff;
   // next-state views so the readies can leave a register
   assign nxt_aw_got = do_wr ? 1'b0 : (aw_got_ff | aw_hs);
   assign nxt_w_got = do_wr ? 1'b0 : (w_got_ff | w_hs);
   assign nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
   assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
   assign status_w = {18'h0, s2_ff.read_cell, 5'h0, ramp_on_ff,
                      (state_ff == SAC_COUNT), done_ff};
   assign rd_ok = (s_axi_araddr == REG_STATUS) | (s_axi_araddr == REG_LEVEL)
                  | (s_axi_araddr == REG_CONFIG) | (s_axi_araddr == REG_COUNT);
   assign rd_mux = (s_axi_araddr == REG_STATUS) ? status_w :
                   (s_axi_araddr == REG_LEVEL) ? {20'h0, level_ff} :
                   (s_axi_araddr == REG_CONFIG) ? 32'(cfg_ff) :
                   (s_axi_araddr == REG_COUNT) ? {20'h0, cnt_ff} : 32'h0;

   // address and data may arrive in either order
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         waddr_ff <= 8'h00;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         level_ff <= LEVEL_RST;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
      end else begin
         // registered readies, same timing as the old decode
         awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
         wready_ff <= ~nxt_w_got & ~nxt_bvalid;
         if (aw_hs) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            // only the level register is writable
            bresp_ff <= (waddr_ff == REG_LEVEL) ? RESP_OKAY : RESP_SLVERR;
            if (waddr_ff == REG_LEVEL) begin
               if (wstrb_ff[0]) level_ff[7:0] <= wdata_ff[7:0];
               if (wstrb_ff[1]) level_ff[11:8] <= wdata_ff[11:8];
            end
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // one read at a time, data registered
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
         arready_ff <= 1'b1;
      end else begin
         arready_ff <= ~nxt_rvalid;
         if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence start_seq;
      state_ff == SAC_IDLE && en_s;
   endsequence
   sequence run_seq;
      state_ff == SAC_COUNT && ramp_on_ff;
   endsequence

   width_map_a: assert property (wsel == 2'h0 |-> full_cnt == 12'h1FF)
      else $error("width select 00 not 9 bit");
   start_ramp_a: assert property (start_seq |=> run_seq)
      else $error("ramp and counter did not start together");
   cnt_hold_a: assert property (!en_s |=> cnt_ff == 12'h000 && !ramp_on_ff)
      else $error("counter not held while enable low");
   done_out_a: assert property (state_ff == SAC_DONE |-> done_ff && cnt_ff == full_cnt)
      else $error("done without full count");
   bus_float_a: assert property (!s2_ff.result_output_enable |=> result_oe_n == 12'hFFF)
      else $error("bus driven while disabled");
   load_copy_a: assert property (s2_ff.result_load |=> out_latch[0] == $past(conv_val[0]))
      else $error("load did not copy result");
   latch_keep_a: assert property (!s2_ff.result_load |=> $stable(out_latch[3]))
      else $error("latch changed without load");
   shift_in_a: assert property (shift_rise && !cfg_clr && !s2_ff.config_readback_select
      |=> shift_ff[0] == $past(s2_ff.config_serial_in))
      else $error("serial bit not shifted in");
   cfg_latch_a: assert property (strobe_rise && !cfg_clr |=> cfg_ff == $past(shift_ff))
      else $error("config not latched");
   cfg_clear_a: assert property (cfg_clr |=> shift_ff == '0 && cfg_ff == '0)
      else $error("config string not cleared");
   cnt_step_a: assert property (step && !$past(state_ff == SAC_IDLE) && en_s
      |=> cnt_ff == $past(cnt_inc))
      else $error("counter missed a converter edge");
endmodule

`default_nettype wire

// ==== tb/sac_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// controller side: holds enable, runs the converter clock
// ----------------------------------------
module sac_ctrl_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic slow,
   input wire logic full_scale_done,
   output logic conv_enable,
   output logic converter_clock
);
   logic [2:0] div_ff; // sys cycles per half period
   // clock stands still outside a conversion, so no stray counts
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_enable <= 1'b0;
         converter_clock <= 1'b0;
         div_ff <= 3'h0;
      end else if (start) begin
         conv_enable <= 1'b1;
      end else if (stop) begin
         conv_enable <= 1'b0;
         converter_clock <= 1'b0;
      end else if (conv_enable && !full_scale_done) begin
         div_ff <= div_ff + 3'h1;
         if (div_ff == (slow ? 3'h7 : 3'h3)) begin
            div_ff <= 3'h0;
            converter_clock <= ~converter_clock;
         end
      end
   end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sac_pkg::*;
   logic clk_sys = 0, rst_n = 0, start = 0, stop = 0, slow = 0;
   logic en, cclk, done, sout, awready, wready, bvalid, arready, rvalid;
   sac_pins_t pb = '0, pw; // bench pins, pins with model fields
   logic [11:0] rdat, oe_n;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, v, pat = 32'hA5C3_1E87;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [1:0] bresp, rresp, rsp;
   int failures = 0, checks_done = 0, cyc = 0;
   always #50 clk_sys = ~clk_sys;
   always_comb begin
      pw = pb;
      pw.conv_enable = en;
      pw.converter_clock = cclk;
   end
   sac_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pw), .full_scale_done(done),
      .result_data(rdat), .result_oe_n(oe_n), .config_serial_out(sout),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   sac_ctrl_model MDL (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .stop(stop), .slow(slow),
      .full_scale_done(done), .conv_enable(en), .converter_clock(cclk));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard: conversions take about 40k cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         $display("[ERR] %0t timeout", $time);
         close_out;
      end
   end
   // write: both halves offered, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd(REG_LEVEL, v, rsp);
      chk({rsp, v}, {RESP_OKAY, 20'h0, LEVEL_RST});
      wr(REG_LEVEL, 32'h0000_0ABC, rsp);
      rd(REG_LEVEL, v, rsp);
      chk({rsp, v}, {RESP_OKAY, 32'h0000_0ABC});
      wr(8'h20, 32'h1, rsp); // unmapped write refused
      chk(rsp, RESP_SLVERR);
      rd(8'h10, v, rsp);
      chk({rsp, v}, {RESP_SLVERR, 32'h0});
      $display("register test done");
   endtask
   task automatic t_cfg;
      for (int i = 31; i >= 0; i--) begin
         pb.config_serial_in <= pat[i];
         wt(4);
         pb.config_shift_clock <= 1'b1;
         wt(4);
         pb.config_shift_clock <= 1'b0;
      end
      pb.config_latch_strobe <= 1'b1;
      wt(6);
      pb.config_latch_strobe <= 1'b0;
      rd(REG_CONFIG, v, rsp);
      chk(v, pat);
      pb.config_readback_select <= 1'b1;
      wt(6);
      for (int k = 31; k >= 24; k--) begin
         chk(sout, pat[k]);
         pb.config_shift_clock <= 1'b1;
         wt(4);
         pb.config_shift_clock <= 1'b0;
         wt(4);
      end
      pb.config_readback_select <= 1'b0;
      pb.config_string_clear <= 1'b1;
      wt(6);
      pb.config_string_clear <= 1'b0;
      rd(REG_CONFIG, v, rsp);
      chk(v, 32'h0);
      $display("config test done");
   endtask
   task automatic t_conv(input logic [1:0] w, input logic z);
      int f, e;
      f = (1 << (9 + w)) - 1;
      pb.write_cell <= 6'h2A;
      pb.read_cell <= 6'h2A;
      pb.cell_write_strobe <= 1'b1;
      pb.width_select_hi <= w[1];
      pb.width_select_lo <= w[0];
      pb.comparator_source_select <= 1'b1;
      pb.comparator_clear <= 1'b1;
      pb.readout_amp_clear <= z;
      pb.correlator_clear <= z;
      slow <= (w == 2'h1);
      wt(4);
      pb.cell_write_strobe <= 1'b0;
      pb.read_enable <= 1'b1;
      pb.memory_output_link <= 1'b1;
      pb.comparator_clear <= 1'b0;
      wt(100);
      start <= 1'b1;
      wt(1);
      start <= 1'b0;
      for (int i = 0; i < 40000 && done !== 1'b1; i++) wt(1);
      rd(REG_COUNT, v, rsp);
      chk(v, f);
      chk(done, 1'b1);
      rd(REG_STATUS, v, rsp);
      chk(v, {18'h0, 6'h2A, 8'h01});
      pb.result_load <= 1'b1;
      pb.result_output_enable <= 1'b1;
      wt(6);
      pb.result_load <= 1'b0;
      chk(oe_n, 12'h000);
      for (int c = 10; c > 0; c -= 9) begin
         e = (z ? 12'h000 : 12'hABC) + c + w;
         pb.channel_select <= 5'(c + w);
         wt(6);
         chk(rdat, (e > f) ? f : e);
      end
      pb.result_output_enable <= 1'b0;
      wt(6);
      chk({oe_n, rdat}, 24'hFFF000);
      stop <= 1'b1;
      wt(1);
      stop <= 1'b0;
      wt(6);
      chk(done, 1'b0);
      rd(REG_COUNT, v, rsp);
      chk(v, 32'h0);
      $display("conversion mode %0d done", w);
   endtask
   initial begin
      wt(20);
      rst_n <= 1'b1;
      wt(2);
      chk({oe_n, rdat}, 24'hFFF000);
      t_regs;
      t_cfg;
      for (int w = 0; w < 4; w++) t_conv(w[1:0], 1'b0);
      t_conv(2'h0, 1'b1);
      close_out;
   end
endmodule

`default_nettype wire
